/* File: rtl/swg_regs.svh */
/*
  Register map, field positions and reset values of the SRAM guard.
  Assumes inclusion by bare name from the package and the wrapper.
*/
`ifndef SWG_REGS_SVH
`define SWG_REGS_SVH
`define SWG_OFF_CTRL      8'h00
`define SWG_OFF_INJ_DATA  8'h04
`define SWG_OFF_INJ_CODE  8'h08
`define SWG_OFF_CE_COUNT  8'h0C
`define SWG_OFF_CE_THRESH 8'h10
`define SWG_OFF_STATUS    8'h14
`define SWG_OFF_CODE_ADDR 8'h18
`define SWG_OFF_CODE_DATA 8'h1C
`define SWG_OFF_PROT      8'h20
`define SWG_CTRL_TEST     0
`define SWG_CTRL_THR_EN   1
`define SWG_STAT_UE       0
`define SWG_STAT_VIOL     1
`define SWG_STAT_MST      2
`define SWG_STAT_BLK      4
`define SWG_PROT_FETCH    0
`define SWG_PROT_WRITE    3
`define SWG_PROT_RST      6'h3F
`define SWG_THRESH_RST    16'hFFFF
`define SWG_CNT_MAX       16'hFFFF
`define SWG_MASTERS       3
`define SWG_DW            32
`define SWG_CW            21
`define SWG_PCW           7
`endif

/* File: rtl/swg_pkg.sv */
/*
  Types shared by the SRAM guard and its bench.
  Assumes the master arbiter presents one access at a time.
*/
`include "swg_regs.svh"
package swg_pkg;
  typedef enum logic [1:0] {
    swg_read  = 2'b00,
    swg_write = 2'b01,
    swg_fetch = 2'b10,
    swg_scrub = 2'b11
  } swg_kind_t;

  typedef struct packed {
    logic [1:0]  master;
    swg_kind_t   kind;
    logic [15:0] addr;
    logic [31:0] wdata;
  } swg_acc_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } swg_reg_t;
endpackage

/* File: rtl/swg_sram_guard.sv */
/*
  SRAM wrapper with check-code generation, checking, correction,
  error injection and per-master fetch/write blocking.
  Assumes one access per cycle from an outside arbiter, a one-cycle
  register port, and a single clock for all of it.
*/
// Our own choices: the register offsets and the address-and-strobe port.
`include "swg_regs.svh"
module swg_sram_guard #(
  parameter int AW          = 10,
  parameter int NUM_BLOCKS  = 4,
  parameter int LOW_BLOCKS  = 2,
  parameter bit PARITY_MODE = 1'b0
)(
  input  wire logic             clk,              // System clock.
  input  wire logic             rst_n,            // Synchronous reset.
  input  wire logic             acc_valid,        // Access request.
  input  wire swg_pkg::swg_acc_t acc,             // Access fields.
  output logic                  acc_ready,        // Access taken.
  output logic                  rd_valid,         // Read data valid.
  output logic [31:0]           rd_data,          // Checked data.
  output logic                  acc_blocked,      // Access refused.
  input  wire swg_pkg::swg_reg_t rbus,            // Register port.
  output logic [31:0]           reg_rdata,        // Register data.
  output logic                  ce_irq,           // Threshold interrupt.
  output logic                  nmi,              // Fatal error pulse.
  output logic                  error_status_pin  // Fatal error level.
);
  import swg_pkg::*;

  localparam int BW = $clog2(NUM_BLOCKS);
  localparam int WW = `SWG_DW + `SWG_CW;

  if (AW > 16 || AW <= BW || LOW_BLOCKS > NUM_BLOCKS
      || NUM_BLOCKS < 2 || (1 << BW) != NUM_BLOCKS)
  begin : g_bad_param
    $error("swg_sram_guard: unsupported parameters");
  end

  function automatic logic [6:0] col(input int idx);
    logic [6:0] c;
    int         n;
    c = '0;
    n = 0;
    for (int v = 0; v < 128; v++)
    begin
      if ($countones(7'(v)) == 3)
      begin
        if (n == idx)
          c = 7'(v);
        n++;
      end
    end
    return c;
  endfunction

  function automatic logic [6:0] ecc7(input logic [15:0] d);
    logic [6:0] c;
    c = '0;
    for (int i = 0; i < 16; i++)
      if (d[i])
        c = c ^ col(i);
    return c;
  endfunction

  // Three 7-bit codes, or three parity bits in parity mode: low half, high half, address.
  function automatic logic [20:0] gen_code(input logic [31:0] d,
                                           input logic [15:0] a);
    if (PARITY_MODE)
      return {{18{1'b0}}, ^a, ^d[31:16], ^d[15:0]};
    return {ecc7(a), ecc7(d[31:16]), ecc7(d[15:0])};
  endfunction

  logic [WW-1:0]   mem [2**AW];
  logic [WW-1:0]   s1_raw;
  logic            s1_valid;
  swg_kind_t       s1_kind;
  logic [AW-1:0]   s1_addr;
  logic [1:0]      ctrl;
  logic [31:0]     inj_data;
  logic [20:0]     inj_code;
  logic [15:0]     ce_count;
  logic [15:0]     ce_thresh;
  logic            viol_flag;
  logic [1:0]      viol_master;
  logic [BW-1:0]   viol_block;
  logic [AW-1:0]   code_addr;
  logic [5:0]      prot [NUM_BLOCKS];
  logic [31:0]     rd_mux;

  // Access decode.
  wire logic          acc_take = acc_valid && acc_ready;
  wire logic [AW-1:0] acc_a    = acc.addr[AW-1:0];
  wire logic [BW-1:0] acc_blk  = acc.addr[AW-1 -: BW];
  wire logic [5:0]    blk_prot = prot[acc_blk];
  wire logic          prot_on  = int'(acc_blk) >= LOW_BLOCKS;
  wire logic          mst_ok   = acc.master != 2'h3;
  wire logic fetch_ok = !prot_on
    || (mst_ok && blk_prot[`SWG_PROT_FETCH + int'(acc.master)]);
  wire logic write_ok = !prot_on
    || (mst_ok && blk_prot[`SWG_PROT_WRITE + int'(acc.master)]);
  wire logic is_write = acc.kind == swg_write;
  wire logic blocked  = acc_take
    && ((is_write && !write_ok) || (acc.kind == swg_fetch && !fetch_ok));
  wire logic do_write = acc_take && is_write && write_ok;
  wire logic do_read  = acc_take && !is_write && !blocked;
  wire logic test_on  = ctrl[`SWG_CTRL_TEST];

  // Stored word is {code, data}; test mode flips chosen bits.
  wire logic [31:0] inj_d   = test_on ? inj_data : '0;
  wire logic [20:0] inj_c   = test_on ? inj_code : '0;
  wire logic [15:0] acc_a16 = 16'(acc_a);
  wire logic [WW-1:0] wr_word =
    {gen_code(acc.wdata, acc_a16) ^ inj_c, acc.wdata ^ inj_d};

  // Check of the raw memory output.
  wire logic [15:0] s1_a16 = 16'(s1_addr);
  wire logic [20:0] s1_code = s1_raw[WW-1:`SWG_DW];
  logic [31:0] fixed;
  logic [1:0]  p_single;
  logic [1:0]  p_dbl;
  logic [1:0]  p_perr;

  for (genvar p = 0; p < 2; p++)
  begin : g_portion
    wire logic [15:0] d   = s1_raw[p*16 +: 16];
    wire logic [6:0]  syn = s1_code[p*`SWG_PCW +: `SWG_PCW] ^ ecc7(d);
    logic [15:0] hit;
    for (genvar i = 0; i < 16; i++)
    begin : g_bit
      assign hit[i]         = syn == col(i);
      assign fixed[p*16+i]  = d[i] ^ hit[i];
    end
    assign p_single[p] = (|hit) || ($countones(syn) == 1);
    assign p_dbl[p]    = (syn != '0) && !p_single[p];
    assign p_perr[p]   = s1_code[p] ^ (^d);
  end

  wire logic [6:0] a_syn  = s1_code[2*`SWG_PCW +: `SWG_PCW] ^ ecc7(s1_a16);
  wire logic       a_perr = s1_code[2] ^ (^s1_a16);
  // No enable gates these: checking runs from reset.
  wire logic ue_det = PARITY_MODE ? ((|p_perr) || a_perr)
                                  : ((|p_dbl) || (a_syn != '0));
  wire logic ue_ev  = s1_valid && ue_det;
  wire logic ce_ev  = s1_valid && !PARITY_MODE && (|p_single) && !ue_det;
  wire logic [31:0] out_data = PARITY_MODE ? s1_raw[31:0] : fixed;
  wire logic wb_en = ce_ev && s1_kind == swg_scrub;
  wire logic [WW-1:0] wb_word = {gen_code(fixed, s1_a16), fixed};

  // Register decode.
  wire logic wr_ctrl   = rbus.wr && rbus.addr == `SWG_OFF_CTRL;
  wire logic wr_injd   = rbus.wr && rbus.addr == `SWG_OFF_INJ_DATA;
  wire logic wr_injc   = rbus.wr && rbus.addr == `SWG_OFF_INJ_CODE;
  wire logic wr_cnt    = rbus.wr && rbus.addr == `SWG_OFF_CE_COUNT;
  wire logic wr_thr    = rbus.wr && rbus.addr == `SWG_OFF_CE_THRESH;
  wire logic wr_stat   = rbus.wr && rbus.addr == `SWG_OFF_STATUS;
  wire logic wr_caddr  = rbus.wr && rbus.addr == `SWG_OFF_CODE_ADDR;
  wire logic clr_ue    = wr_stat && rbus.wdata[`SWG_STAT_UE];
  wire logic clr_viol  = wr_stat && rbus.wdata[`SWG_STAT_VIOL];
  wire logic prot_hit  = int'(rbus.addr) >= int'(`SWG_OFF_PROT)
    && int'(rbus.addr) < int'(`SWG_OFF_PROT) + 4 * NUM_BLOCKS
    && rbus.addr[1:0] == 2'h0;
  wire logic [BW-1:0] prot_idx = BW'((rbus.addr - `SWG_OFF_PROT) >> 2);
  wire logic [15:0] cnt_base = wr_cnt ? 16'h0000 : ce_count;
  wire logic [15:0] next_ce_count =
    (ce_ev && cnt_base != `SWG_CNT_MAX) ? cnt_base + 16'h0001 : cnt_base;
  wire logic [20:0] code_rd = mem[code_addr][WW-1:`SWG_DW];

  always_comb
  begin
    rd_mux = '0;
    unique case (rbus.addr)
      `SWG_OFF_CTRL:      rd_mux = {30'h0, ctrl};
      `SWG_OFF_INJ_DATA:  rd_mux = inj_data;
      `SWG_OFF_INJ_CODE:  rd_mux = {11'h0, inj_code};
      `SWG_OFF_CE_COUNT:  rd_mux = {16'h0, ce_count};
      `SWG_OFF_CE_THRESH: rd_mux = {16'h0, ce_thresh};
      `SWG_OFF_STATUS:    rd_mux = 32'({viol_block, viol_master,
                                        viol_flag, error_status_pin});
      `SWG_OFF_CODE_ADDR: rd_mux = 32'(code_addr);
      `SWG_OFF_CODE_DATA: rd_mux = {11'h0, code_rd};
      default:
        if (prot_hit)
          rd_mux = {26'h0, prot[prot_idx]};
    endcase
  end

  // Memory array; a scrub write-back owns the port while ready is low.
  always_ff @(posedge clk)
  begin
    if (wb_en)
      mem[s1_addr] <= wb_word;
    else if (do_write)
      mem[acc_a] <= wr_word;
    if (do_read)
      s1_raw <= mem[acc_a];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_valid  <= 1'b0;
      s1_kind   <= swg_read;
      s1_addr   <= '0;
      acc_ready <= 1'b1;
    end
    else
    begin
      s1_valid  <= do_read;
      s1_kind   <= acc.kind;
      s1_addr   <= acc_a;
      acc_ready <= !(do_read && acc.kind == swg_scrub && !PARITY_MODE);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_valid    <= 1'b0;
      rd_data     <= '0;
      acc_blocked <= 1'b0;
      nmi         <= 1'b0;
    end
    else
    begin
      rd_valid    <= s1_valid;
      rd_data     <= s1_valid ? out_data : '0;
      acc_blocked <= blocked;
      nmi         <= ue_ev;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl      <= '0;
      inj_data  <= '0;
      inj_code  <= '0;
      ce_thresh <= `SWG_THRESH_RST;
      code_addr <= '0;
      reg_rdata <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= rbus.wdata[1:0];
      if (wr_injd)
        inj_data <= rbus.wdata;
      if (wr_injc)
        inj_code <= rbus.wdata[20:0];
      if (wr_thr)
        ce_thresh <= rbus.wdata[15:0];
      if (wr_caddr)
        code_addr <= rbus.wdata[AW-1:0];
      reg_rdata <= rbus.rd ? rd_mux : '0;
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ce_count         <= '0;
      ce_irq           <= 1'b0;
      error_status_pin <= 1'b0;
      viol_flag        <= 1'b0;
      viol_master      <= '0;
      viol_block       <= '0;
    end
    else
    begin
      ce_count         <= next_ce_count;
      ce_irq           <= ctrl[`SWG_CTRL_THR_EN] && ce_count > ce_thresh;
      error_status_pin <= ue_ev || (error_status_pin && !clr_ue);
      viol_flag        <= blocked || (viol_flag && !clr_viol);
      if (blocked)
      begin
        viol_master <= acc.master;
        viol_block  <= acc_blk;
      end
    end
  end

  // Protection words are live: a write applies to the next access.
  for (genvar b = 0; b < NUM_BLOCKS; b++)
  begin : g_prot
    wire logic we = rbus.wr && prot_hit && int'(prot_idx) == b;
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        prot[b] <= `SWG_PROT_RST;
      else if (we)
        prot[b] <= rbus.wdata[5:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_read_after_check: assert property (
    do_read |=> s1_valid ##1 rd_valid)
    else $error("read data not returned two cycles after request");

  a_ce_count_step: assert property (
    ce_ev && !wr_cnt && ce_count != `SWG_CNT_MAX
      |=> ce_count == $past(ce_count) + 16'h0001)
    else $error("corrected count did not step");

  a_threshold_irq: assert property (
    ctrl[`SWG_CTRL_THR_EN] && ce_count > ce_thresh |=> ce_irq)
    else $error("threshold interrupt missing");

  a_fatal_outputs: assert property (
    ue_ev |=> nmi && error_status_pin)
    else $error("fatal error not signalled");

  a_check_no_enable: assert property (
    ctrl == 2'h0 && s1_valid && ue_det |=> nmi)
    else $error("checking needs a software enable");

  a_write_blocked: assert property (
    acc_take && is_write && !write_ok |=> acc_blocked && viol_flag)
    else $error("blocked write not flagged");

  a_read_open: assert property (
    acc_take && acc.kind == swg_read |=> !acc_blocked ##1 rd_valid)
    else $error("read was blocked");

  a_low_open: assert property (
    acc_take && !prot_on |=> !acc_blocked)
    else $error("low block access refused");

  a_scrub_stall: assert property (
    acc_take && acc.kind == swg_scrub && !PARITY_MODE |=> !acc_ready ##1 acc_ready)
    else $error("scrub did not reserve the write-back slot");

  a_count_sat: assert property (
    ce_count == `SWG_CNT_MAX && !wr_cnt |=> ce_count == `SWG_CNT_MAX)
    else $error("corrected count wrapped");

  c_corrected: cover property (ce_ev ##1 rd_valid);
  c_fatal: cover property (ue_ev ##1 nmi);
  c_scrub_fix: cover property (wb_en);
  c_blocked_fetch: cover property (blocked && acc.kind == swg_fetch);
endmodule

/* File: testbench/swg_master_model.sv */
/*
  Bus master model standing for the CPU, coprocessor and DMA side.
  Assumes the guard's access port and one clock shared with it.
*/
module swg_master_model (
  input  wire logic        clk,        // System clock.
  input  wire logic        acc_ready,  // Guard takes the request.
  output logic             acc_valid,  // Access request.
  output swg_pkg::swg_acc_t acc        // Access fields.
);
  timeunit 1ns;
  timeprecision 1ps;
  import swg_pkg::*;

  initial
  begin
    acc_valid = 1'b0;
    acc       = '0;
  end

  // Holds the request until ready is sampled high; the released bus shows
  // inverted fields so stale values are never mistaken for live ones.
  task automatic issue(input int idle, input swg_acc_t a);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc       <= a;
    do @(posedge clk); while (acc_ready !== 1'b1);
    acc_valid <= 1'b0;
    acc       <= ~a;
  endtask
endmodule

/* File: testbench/swg_sram_guard_tb.sv */
/*
  Self-checking bench of the SRAM guard in ECC mode and in parity mode.
  Assumes the register map and access timing of the guard's hand-over;
  both guards share the access and register ports.
*/
`include "swg_regs.svh"
`define SWG_CHK(g, e) \
  begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module swg_sram_guard_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swg_pkg::*;

  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              acc_valid;
  swg_acc_t          acc;
  logic              acc_ready;
  logic              rd_valid;
  logic [31:0]       rd_data;
  logic              acc_blocked;
  swg_reg_t          rbus = '0;
  logic [31:0]       reg_rdata;
  logic              ce_irq;
  logic              nmi;
  logic              error_status_pin;
  logic              rd_valid_p;
  logic [31:0]       rd_data_p;
  logic [31:0]       reg_rdata_p;
  logic              nmi_p;
  logic              error_status_pin_p;
  int                bad_count = 0;
  int                n_compared = 0;

  always #2.5 clk = ~clk;

  swg_sram_guard i_swg_sram_guard (.clk(clk), .rst_n(rst_n), .acc_valid(acc_valid),
    .acc(acc), .acc_ready(acc_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .acc_blocked(acc_blocked), .rbus(rbus), .reg_rdata(reg_rdata), .ce_irq(ce_irq),
    .nmi(nmi), .error_status_pin(error_status_pin));

  swg_master_model i_swg_master_model (.clk(clk), .acc_ready(acc_ready),
    .acc_valid(acc_valid), .acc(acc));

  // Parity-mode guard; it never stalls, so the model follows the ECC guard's ready.
  swg_sram_guard #(.PARITY_MODE(1'b1)) i_swg_sram_guard_par (.clk(clk), .rst_n(rst_n),
    .acc_valid(acc_valid), .acc(acc), .acc_ready(), .rd_valid(rd_valid_p),
    .rd_data(rd_data_p), .acc_blocked(), .rbus(rbus), .reg_rdata(reg_rdata_p),
    .ce_irq(), .nmi(nmi_p), .error_status_pin(error_status_pin_p));

  function automatic logic [6:0] hs(input logic [15:0] d);
    logic [6:0] c;
    int         n;
    c = '0;
    n = 0;
    for (int v = 0; v < 128; v++)
      if ($countones(7'(v)) == 3 && n < 16)
      begin
        if (d[n]) c ^= 7'(v);
        n++;
      end
    return c;
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rbus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    rbus <= '{a, ~d, 1'b0, 1'b0};
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rbus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    rbus.rd <= 1'b0;
    #1 `SWG_CHK(reg_rdata, e)
  endtask

  // Fetch or write; checks the refusal pulse in the cycle after the take.
  task automatic wr_chk(input logic [1:0] m, input swg_kind_t k, input logic [15:0] a,
                        input logic [31:0] d, input logic b);
    i_swg_master_model.issue(0, '{m, k, a, d});
    #1 `SWG_CHK(acc_blocked, b)
    @(posedge clk);
    #1 `SWG_CHK(rd_valid, 1'b0)
  endtask

  // Read, fetch or scrub; data is judged only when no fatal error is due.
  task automatic rd_chk(input logic [1:0] m, input swg_kind_t k, input logic [15:0] a,
                        input logic [31:0] d, input logic f);
    i_swg_master_model.issue(1, '{m, k, a, 32'h0000_0000});
    #1 `SWG_CHK(acc_ready, k != swg_scrub)
    @(posedge clk);
    #1 `SWG_CHK({rd_valid, nmi}, {1'b1, f})
    if (!f) `SWG_CHK(rd_data, d)
  endtask

  // Read on the parity-mode guard; data is judged only when no fatal error is due.
  task automatic par_rd_chk(input logic [15:0] a, input logic [31:0] d, input logic f);
    i_swg_master_model.issue(1, '{2'h0, swg_read, a, 32'h0000_0000});
    @(posedge clk);
    #1 `SWG_CHK({rd_valid_p, nmi_p}, {1'b1, f})
    if (!f) `SWG_CHK(rd_data_p, d)
  endtask

  task automatic par_reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rbus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    rbus.rd <= 1'b0;
    #1 `SWG_CHK(reg_rdata_p, e)
  endtask

  task automatic t_reset;
    reg_chk(`SWG_OFF_CTRL, 32'h0000_0000);
    reg_chk(`SWG_OFF_CE_THRESH, 32'h0000_FFFF);
    reg_chk(8'h28, 32'h0000_003F);
    reg_chk(8'hFC, 32'h0000_0000);
    `SWG_CHK(error_status_pin, 1'b0)
  endtask

  task automatic t_clean;
    wr_chk(0, swg_write, 16'h0204, 32'hA5C3_1E07, 1'b0);
    rd_chk(0, swg_read, 16'h0204, 32'hA5C3_1E07, 1'b0);
    reg_wr(`SWG_OFF_CODE_ADDR, 32'h0000_0204);
    reg_chk(`SWG_OFF_CODE_DATA, {11'h0, hs(16'h0204), hs(16'hA5C3), hs(16'h1E07)});
    rd_chk(2, swg_fetch, 16'h0204, 32'hA5C3_1E07, 1'b0);
  endtask

  // One corrected read counts once, whatever the number of portions fixed.
  task automatic t_single;
    reg_wr(`SWG_OFF_CTRL, 32'h0000_0001);
    reg_wr(`SWG_OFF_INJ_DATA, 32'h0010_0200);
    wr_chk(0, swg_write, 16'h0208, 32'h0F0F_3355, 1'b0);
    reg_wr(`SWG_OFF_CTRL, 32'h0000_0000);
    rd_chk(1, swg_read, 16'h0208, 32'h0F0F_3355, 1'b0);
    reg_chk(`SWG_OFF_CE_COUNT, 32'h0000_0001);
    reg_wr(`SWG_OFF_CE_THRESH, 32'h0000_0000);
    reg_wr(`SWG_OFF_CTRL, 32'h0000_0002);
    repeat (2) @(posedge clk);
    #1 `SWG_CHK(ce_irq, 1'b1)
    rd_chk(0, swg_scrub, 16'h0208, 32'h0F0F_3355, 1'b0);
    rd_chk(0, swg_read, 16'h0208, 32'h0F0F_3355, 1'b0);
    reg_chk(`SWG_OFF_CE_COUNT, 32'h0000_0002);
    reg_wr(`SWG_OFF_CE_COUNT, 32'h0000_0000);
    reg_chk(`SWG_OFF_CE_COUNT, 32'h0000_0000);
    #1 `SWG_CHK(ce_irq, 1'b0)
  endtask

  task automatic t_fatal;
    reg_wr(`SWG_OFF_CTRL, 32'h0000_0001);
    reg_wr(`SWG_OFF_INJ_DATA, 32'h0000_0003);
    wr_chk(0, swg_write, 16'h020C, 32'h1234_5678, 1'b0);
    reg_wr(`SWG_OFF_INJ_DATA, 32'h0000_0000);
    reg_wr(`SWG_OFF_INJ_CODE, 32'h0000_4000);
    wr_chk(0, swg_write, 16'h0210, 32'h1234_5678, 1'b0);
    reg_wr(`SWG_OFF_CTRL, 32'h0000_0000);
    rd_chk(0, swg_read, 16'h020C, 32'h1234_5678, 1'b1);
    `SWG_CHK(error_status_pin, 1'b1)
    rd_chk(0, swg_read, 16'h0210, 32'h1234_5678, 1'b1);
    reg_chk(`SWG_OFF_CE_COUNT, 32'h0000_0000);
    reg_chk(`SWG_OFF_STATUS, 32'h0000_0001);
  endtask

  task automatic t_protect;
    wr_chk(0, swg_write, 16'h0220, 32'hCAFE_0001, 1'b0);
    reg_wr(8'h28, 32'h0000_002D);
    wr_chk(1, swg_write, 16'h0220, 32'h0BAD_0002, 1'b1);
    wr_chk(1, swg_fetch, 16'h0220, 32'h0000_0000, 1'b1);
    rd_chk(1, swg_read, 16'h0220, 32'hCAFE_0001, 1'b0);
    reg_chk(`SWG_OFF_STATUS, 32'h0000_0027);
    reg_wr(8'h20, 32'h0000_0000);
    wr_chk(3, swg_write, 16'h0030, 32'h0BAD_0003, 1'b0);
    rd_chk(3, swg_fetch, 16'h0030, 32'h0BAD_0003, 1'b0);
    reg_wr(8'h28, 32'h0000_003F);
    wr_chk(1, swg_write, 16'h0220, 32'h0BAD_0004, 1'b0);
    rd_chk(1, swg_fetch, 16'h0220, 32'h0BAD_0004, 1'b0);
  endtask

  // Clearing both sticky flags keeps the last violator's master and block.
  task automatic t_parity;
    reg_wr(`SWG_OFF_STATUS, 32'h0000_0003);
    reg_chk(`SWG_OFF_STATUS, 32'h0000_0024);
    #1 `SWG_CHK(error_status_pin_p, 1'b0)
    reg_wr(`SWG_OFF_INJ_CODE, 32'h0000_0000);
    wr_chk(0, swg_write, 16'h0240, 32'h1357_9BDF, 1'b0);
    par_rd_chk(16'h0240, 32'h1357_9BDF, 1'b0);
    reg_wr(`SWG_OFF_CODE_ADDR, 32'h0000_0240);
    par_reg_chk(`SWG_OFF_CODE_DATA, {29'h0, ^16'h0240, ^16'h1357, ^16'h9BDF});
    reg_wr(`SWG_OFF_INJ_DATA, 32'h0001_0000);
    reg_wr(`SWG_OFF_CTRL, 32'h0000_0001);
    wr_chk(0, swg_write, 16'h0244, 32'h2468_ACE0, 1'b0);
    reg_wr(`SWG_OFF_INJ_DATA, 32'h0000_0000);
    reg_wr(`SWG_OFF_INJ_CODE, 32'h0000_0001);
    wr_chk(0, swg_write, 16'h0248, 32'h2468_ACE0, 1'b0);
    reg_wr(`SWG_OFF_CTRL, 32'h0000_0000);
    par_rd_chk(16'h0244, 32'h2468_ACE0, 1'b1);
    `SWG_CHK(error_status_pin_p, 1'b1)
    par_rd_chk(16'h0248, 32'h2468_ACE0, 1'b1);
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_clean();
    t_single();
    t_fatal();
    t_protect();
    t_parity();
    complete_run();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
